// *** tmon_defines.vh ***
// constants for the temperature monitor register bank
`ifndef TMON_DEFINES_VH
`define TMON_DEFINES_VH
// read addresses
`define TMON_RA_LOCAL_VAL   8'h00
`define TMON_RA_REM_VAL_H   8'h01
`define TMON_RA_STATUS1     8'h02
`define TMON_RA_CONFIG      8'h03
`define TMON_RA_RATE        8'h04
`define TMON_RA_LOC_HI      8'h05
`define TMON_RA_LOC_LO      8'h06
`define TMON_RA_REM_HI_H    8'h07
`define TMON_RA_REM_LO_H    8'h08
// write addresses of the split part of the map
`define TMON_WA_CONFIG      8'h09
`define TMON_WA_RATE        8'h0a
`define TMON_WA_LOC_HI      8'h0b
`define TMON_WA_LOC_LO      8'h0c
`define TMON_WA_REM_HI_H    8'h0d
`define TMON_WA_REM_LO_H    8'h0e
`define TMON_WA_ONE_SHOT    8'h0f
// shared read/write addresses, plus read-only remote low byte at 0x10 and status two at 0x23
`define TMON_A_REM_VAL_L    8'h10
`define TMON_A_OFF_H        8'h11
`define TMON_A_OFF_L        8'h12
`define TMON_A_REM_HI_L     8'h13
`define TMON_A_REM_LO_L     8'h14
`define TMON_A_OVERTEMP_OUT_N        8'h19
`define TMON_A_FILTER       8'h22
`define TMON_RA_STATUS2     8'h23
`define TMON_A_OFF2_H       8'h34
`define TMON_A_OFF2_L       8'h35
// field positions
`define TMON_CFG_BANK       3
`define TMON_CFG_STANDBY    6
`define TMON_FLT_SCL_TMO    7
`define TMON_FLT_SDA_TMO    6
`define TMON_FLT_MASK_LOC   5
`define TMON_FLT_RSVD_MASK  8'hef
`define TMON_OFFL_MASK      8'hc0
// reset values
`define TMON_RST_ZERO       8'h00
`define TMON_RST_RATE       8'h07
`define TMON_RST_LIMIT85    8'h55
`define TMON_RST_FILTER     8'h01
// timing and slave address
`define TMON_TMO_MS         25
`define TMON_SLV_ADDR       7'h4c
`endif

// *** tmon_regs.v ***
// register bank with serial slave, offset correction and limit filtering
// How it works
// [RQ1] offsets are ten-bit signed quarter-degree values
// [RQ2] channel one offset at 0x11 and 0x12
// [RQ3] channel two offset at 0x34 and 0x35
// [RQ4] config bit 3 steers offset access
// [RQ5] low offset byte keeps bits 7:6 only
// [RQ6] offset spans minus 128 to 127.75
// [RQ7] offset added to raw remote reading
// [RQ8] offsets reset to zero
// [RQ9] write 0x0f in standby starts one conversion
// [RQ10] host ignores alarm outputs in one-shot mode
// [RQ11] alarm after one to four consecutive faults
// [RQ12] filter register at 0x22, bit 4 reserved
// [RQ13] bit 7 enables clock-line timeout
// [RQ14] bit 6 enables data-line timeout
// [RQ15] bit 5 masks local limit alarms
// [RQ16] control registers read 03-08, write 09-0e
// [RQ17] temperature high byte banked by config bit
// [RQ18] temperature low byte banked, resets zero
// [RQ19] remote high limit resets 0x55, banked
// [RQ20] remote high limit low byte at 0x13
// [RQ21] overtemp limit at 0x19 resets 0x55
// [RQ22] unmasked flags latch the alarm output
// [RQ23] status read clears only gone conditions
// [RQ24] fault counter restarts on in-limit reading
`timescale 1ns/1ps
`include "tmon_defines.vh"
module tmon_regs #(
   parameter CLK_MHZ     = 100,                             // core clock rate
   parameter TIMEOUT_CYC = `TMON_TMO_MS * 1000 * CLK_MHZ    // bus inactivity timeout in cycles
) (
   input  wire       core_clk_in,     // core clock
   input  wire       rst_n_in,        // async reset, active low
   input  wire       scl_in,          // serial clock pin
   input  wire       sda_in,          // serial data pin level
   output wire       sda_out,         // data drive level, always low
   output wire       sda_oe_out,      // data pull-down enable
   input  wire       meas_valid_in,   // one-cycle strobe from converter
   input  wire [1:0] meas_chan_in,    // 0 local, 1 remote one, 2 remote two
   input  wire [9:0] meas_raw_in,     // raw reading, 8.2 format
   input  wire       meas_busy_in,    // converter busy level
   input  wire       open1_in,        // remote one sensor open
   input  wire       open2_in,        // remote two sensor open
   output wire       one_shot_out,    // one-cycle conversion request
   output wire       alert_n_out,     // alarm, active low
   output wire       overtemp_n_out   // overtemp comparator, active low
);
   // slave states, one-hot
   localparam [4:0] ST_IDLE = 5'b00001;
   localparam [4:0] ST_ADDR = 5'b00010;
   localparam [4:0] ST_PTR  = 5'b00100;
   localparam [4:0] ST_DATA = 5'b01000;
   localparam [4:0] ST_READ = 5'b10000;
   localparam [21:0] TMO_LIM = TIMEOUT_CYC[21:0];

   // pin synchronisers plus a history stage for edges
   reg [2:0] scl_q;                   // [0] first stage, [1] synced, [2] previous
   reg [2:0] sda_q;
   wire      scl_rise = scl_q[1] & ~scl_q[2];
   wire      scl_fall = ~scl_q[1] & scl_q[2];
   wire      bus_start = scl_q[1] & scl_q[2] & ~sda_q[1] & sda_q[2];
   wire      bus_stop  = scl_q[1] & scl_q[2] & sda_q[1] & ~sda_q[2];

   // slave engine
   reg [4:0]  st_q;                   // slave state
   reg [3:0]  bit_q;                  // bits seen in current byte slot
   reg [7:0]  sh_q;                   // shift register
   reg        rw_q;                   // direction of transaction
   reg        mack_q;                 // master acknowledged read byte
   reg [7:0]  ptr_q;                  // register select pointer
   reg        oe_q;                   // pull-down enable
   reg [21:0] tmo_q;                  // inactivity counter

   // register storage
   reg [7:0] cfg_q, rate_q, lhi_q, llo_q, filt_q, lval_q;
   reg [7:0] rhh_q [0:1];             // remote high limit high bytes
   reg [7:0] rlh_q [0:1];             // remote low limit high bytes
   reg [7:0] rhl_q [0:1];             // remote high limit low bytes
   reg [7:0] rll_q [0:1];             // remote low limit low bytes
   reg [7:0] offh_q [0:1];            // offset high bytes
   reg [7:0] offl_q [0:1];            // offset low bytes, bits 7:6 used
   reg [7:0] overtemp_out_n_q [0:1];           // overtemp limits
   reg [9:0] rval_q [0:1];            // corrected remote readings
   reg       one_shot_q;

   // conditions, counters and flags per channel 0..2
   reg [2:0] hi_c_q, lo_c_q, th_c_q;  // live out-of-limit levels
   reg [2:0] hi_f_q, lo_f_q;          // sticky flags
   reg [2:0] open_f_q;                // sticky open flags, [0] unused
   reg [2:0] cnt_q [0:2];             // consecutive fault counts
   reg       alert_n_q, overtemp_n_q;

   wire       bank = cfg_q[`TMON_CFG_BANK];
   reg  [7:0] rd_data;

   // consecutive count needed
   reg  [2:0] need;
   always @* begin
      case (filt_q[3:1])               // [RQ11]
         3'b000:  need = 3'd1;
         3'b001:  need = 3'd2;
         3'b011:  need = 3'd3;
         3'b111:  need = 3'd4;
         default: need = 3'd1;         // odd codes fall back to one
      endcase
   end

   // status images
   wire [7:0] status1 = {meas_busy_in, hi_f_q[0], lo_f_q[0], hi_f_q[1], lo_f_q[1],
                         open_f_q[1], th_c_q[1], th_c_q[0]};
   wire [7:0] status2 = {3'b000, hi_f_q[2], lo_f_q[2], open_f_q[2], th_c_q[2], ~alert_n_q};

   // read mux
   always @* begin
      case (ptr_q)
         `TMON_RA_LOCAL_VAL: rd_data = lval_q;
         `TMON_RA_REM_VAL_H: rd_data = rval_q[bank][9:2];            // [RQ17]
         `TMON_RA_STATUS1:   rd_data = status1;
         `TMON_RA_CONFIG:    rd_data = cfg_q;                         // [RQ16]
         `TMON_RA_RATE:      rd_data = rate_q;
         `TMON_RA_LOC_HI:    rd_data = lhi_q;
         `TMON_RA_LOC_LO:    rd_data = llo_q;
         `TMON_RA_REM_HI_H:  rd_data = rhh_q[bank];                   // [RQ19]
         `TMON_RA_REM_LO_H:  rd_data = rlh_q[bank];
         `TMON_A_REM_VAL_L:  rd_data = {rval_q[bank][1:0], 6'b000000}; // [RQ18]
         `TMON_A_OFF_H:      rd_data = offh_q[bank];                  // [RQ4] [RQ2]
         `TMON_A_OFF_L:      rd_data = offl_q[bank] & `TMON_OFFL_MASK; // [RQ5]
         `TMON_A_REM_HI_L:   rd_data = rhl_q[bank];                   // [RQ20]
         `TMON_A_REM_LO_L:   rd_data = rll_q[bank];
         `TMON_A_OVERTEMP_OUT_N:      rd_data = overtemp_out_n_q[bank];                 // [RQ21]
         `TMON_A_FILTER:     rd_data = filt_q;                        // [RQ12]
         `TMON_RA_STATUS2:   rd_data = status2;
         `TMON_A_OFF2_H:     rd_data = offh_q[1];                     // [RQ3]
         `TMON_A_OFF2_L:     rd_data = offl_q[1] & `TMON_OFFL_MASK;
         default:            rd_data = 8'h00;  // unmapped reads as zero
      endcase
   end

   // slave engine events used by the register file
   wire byte_done = scl_fall & (bit_q == 4'd8);
   wire slot_done = scl_fall & (bit_q == 4'd9);
   wire wr_stb    = byte_done & st_q[3];                 // data byte written
   wire ld_stb    = slot_done & ((st_q[1] & rw_q) | (st_q[4] & mack_q)); // read byte loaded
   wire rd_st1    = ld_stb & (ptr_q == `TMON_RA_STATUS1);
   wire rd_st2    = ld_stb & (ptr_q == `TMON_RA_STATUS2);
   wire tmo_hit   = (tmo_q == TMO_LIM);

   // synchronisers; first stage feeds only the second
   always @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         scl_q <= 3'b111;
         sda_q <= 3'b111;
      end else begin
         scl_q <= {scl_q[1:0], scl_in};
         sda_q <= {sda_q[1:0], sda_in};
      end
   end

   // inactivity timeout, counts while an enabled line sits low
   always @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         tmo_q <= 22'd0;
      end else if (st_q[0] | tmo_hit) begin
         tmo_q <= 22'd0;                                  // idle bus or fired
      end else if ((filt_q[`TMON_FLT_SCL_TMO] & ~scl_q[1]) | // [RQ13]
                   (filt_q[`TMON_FLT_SDA_TMO] & ~sda_q[1])) begin // [RQ14]
         tmo_q <= tmo_q + 22'd1;
      end else begin
         tmo_q <= 22'd0;
      end
   end

   // serial slave state machine
   always @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st_q   <= ST_IDLE;
         bit_q  <= 4'd0;
         sh_q   <= 8'h00;
         rw_q   <= 1'b0;
         mack_q <= 1'b0;
         ptr_q  <= 8'h00;
         oe_q   <= 1'b0;
      end else if (bus_start) begin
         st_q  <= ST_ADDR;                                // also repeated start
         bit_q <= 4'd0;
         oe_q  <= 1'b0;
      end else if (bus_stop | tmo_hit) begin
         st_q  <= ST_IDLE;                                // timeout frees the data line
         oe_q  <= 1'b0;
      end else if (!st_q[0]) begin
         if (scl_rise) begin
            bit_q <= bit_q + 4'd1;
            if (bit_q < 4'd8 && !st_q[4]) begin
               sh_q <= {sh_q[6:0], sda_q[1]};             // receive
            end
            if (bit_q == 4'd8 && st_q[4]) begin
               mack_q <= ~sda_q[1];                       // master ack level
            end
         end else if (scl_fall) begin
            case (bit_q)
               4'd8: begin                                // acknowledge slot
                  if (st_q[1]) begin
                     if (sh_q[7:1] == `TMON_SLV_ADDR) begin
                        oe_q <= 1'b1;
                        rw_q <= sh_q[0];
                     end else begin
                        st_q <= ST_IDLE;                  // not for us
                        oe_q <= 1'b0;
                     end
                  end else if (st_q[4]) begin
                     oe_q <= 1'b0;                        // master owns ack
                  end else begin
                     oe_q <= 1'b1;
                     if (st_q[2]) begin
                        ptr_q <= sh_q;
                     end
                  end
               end
               4'd9: begin                                // slot over
                  bit_q <= 4'd0;
                  if (ld_stb) begin
                     st_q <= ST_READ;
                     sh_q <= rd_data;
                     oe_q <= ~rd_data[7];
                  end else if (st_q[4]) begin
                     st_q <= ST_IDLE;                     // master said no more
                     oe_q <= 1'b0;
                  end else begin
                     st_q <= st_q[1] ? ST_PTR : ST_DATA;
                     oe_q <= 1'b0;
                  end
               end
               default: begin
                  if (st_q[4]) begin
                     oe_q <= ~sh_q[3'd7 - bit_q[2:0]];    // next read bit
                  end
               end
            endcase
         end
      end
   end

   // register writes and one-shot request
   always @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cfg_q      <= `TMON_RST_ZERO;
         rate_q     <= `TMON_RST_RATE;
         lhi_q      <= `TMON_RST_LIMIT85;
         llo_q      <= `TMON_RST_ZERO;
         filt_q     <= `TMON_RST_FILTER;                  // [RQ13] [RQ14] [RQ15]
         rhh_q[0]   <= `TMON_RST_LIMIT85;                 // [RQ19]
         rhh_q[1]   <= `TMON_RST_LIMIT85;
         rlh_q[0]   <= `TMON_RST_ZERO;
         rlh_q[1]   <= `TMON_RST_ZERO;
         rhl_q[0]   <= `TMON_RST_ZERO;                    // [RQ20]
         rhl_q[1]   <= `TMON_RST_ZERO;
         rll_q[0]   <= `TMON_RST_ZERO;
         rll_q[1]   <= `TMON_RST_ZERO;
         offh_q[0]  <= `TMON_RST_ZERO;                    // [RQ8]
         offh_q[1]  <= `TMON_RST_ZERO;
         offl_q[0]  <= `TMON_RST_ZERO;
         offl_q[1]  <= `TMON_RST_ZERO;
         overtemp_out_n_q[0] <= `TMON_RST_LIMIT85;                 // [RQ21]
         overtemp_out_n_q[1] <= `TMON_RST_LIMIT85;
         one_shot_q <= 1'b0;
      end else begin
         one_shot_q <= 1'b0;
         if (wr_stb) begin
            case (ptr_q)
               `TMON_WA_CONFIG:   cfg_q  <= sh_q;         // [RQ16]
               `TMON_WA_RATE:     rate_q <= sh_q;
               `TMON_WA_LOC_HI:   lhi_q  <= sh_q;
               `TMON_WA_LOC_LO:   llo_q  <= sh_q;
               `TMON_WA_REM_HI_H: rhh_q[bank] <= sh_q;
               `TMON_WA_REM_LO_H: rlh_q[bank] <= sh_q;
               // data is dropped, only the write matters
               `TMON_WA_ONE_SHOT: one_shot_q <= cfg_q[`TMON_CFG_STANDBY]; // [RQ9]
               `TMON_A_OFF_H:     offh_q[bank] <= sh_q;  // [RQ4]
               `TMON_A_OFF_L:     offl_q[bank] <= sh_q & `TMON_OFFL_MASK; // [RQ5]
               `TMON_A_REM_HI_L:  rhl_q[bank] <= sh_q;
               `TMON_A_REM_LO_L:  rll_q[bank] <= sh_q;
               `TMON_A_OVERTEMP_OUT_N:     overtemp_out_n_q[bank] <= sh_q;
               `TMON_A_FILTER:    filt_q <= sh_q & `TMON_FLT_RSVD_MASK; // [RQ12]
               `TMON_A_OFF2_H:    offh_q[1] <= sh_q;     // [RQ3]
               `TMON_A_OFF2_L:    offl_q[1] <= sh_q & `TMON_OFFL_MASK;
               default: ;                                 // read-only or unmapped
            endcase
         end
      end
   end

   // offset correction for the addressed remote channel
   wire        rsel   = (meas_chan_in == 2'd2);
   wire [9:0]  offs   = {offh_q[rsel], offl_q[rsel][7:6]};           // [RQ1] [RQ6]
   wire [11:0] sum    = {2'b00, meas_raw_in} + {{2{offs[9]}}, offs}; // [RQ7]
   // clamp keeps the stored value inside the 0..255.75 range
   wire [9:0]  corr   = sum[11] ? 10'h000 : (sum[10] ? 10'h3ff : sum[9:0]);
   wire        is_rem = (meas_chan_in == 2'd1) | rsel;
   wire        m_hi   = is_rem ? (corr > {rhh_q[rsel], rhl_q[rsel][7:6]})
                               : (meas_raw_in[9:2] > lhi_q);
   wire        m_lo   = is_rem ? (corr <= {rlh_q[rsel], rll_q[rsel][7:6]})
                               : (meas_raw_in[9:2] <= llo_q);
   wire        m_th   = is_rem & (corr[9:2] > overtemp_out_n_q[rsel]);
   wire [1:0]  ch     = (meas_chan_in == 2'd3) ? 2'd0 : meas_chan_in;
   wire        m_trip = (m_hi | m_lo) & ((cnt_q[ch] + 3'd1) >= need);

   // measurement capture, counters and sticky flags
   integer i;
   always @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         lval_q    <= `TMON_RST_ZERO;
         rval_q[0] <= 10'h000;                            // [RQ18]
         rval_q[1] <= 10'h000;
         hi_c_q    <= 3'b000;
         lo_c_q    <= 3'b000;
         th_c_q    <= 3'b000;
         hi_f_q    <= 3'b000;
         lo_f_q    <= 3'b000;
         open_f_q  <= 3'b000;
         for (i = 0; i < 3; i = i + 1) begin
            cnt_q[i] <= 3'd0;
         end
      end else begin
         // reading status clears a flag only once its cause is gone; a new set wins
         for (i = 0; i < 3; i = i + 1) begin
            if (((i == 2) ? rd_st2 : rd_st1) && !hi_c_q[i]) hi_f_q[i] <= 1'b0; // [RQ23]
            if (((i == 2) ? rd_st2 : rd_st1) && !lo_c_q[i]) lo_f_q[i] <= 1'b0;
         end
         if (rd_st1 && !open1_in) open_f_q[1] <= 1'b0;
         if (rd_st2 && !open2_in) open_f_q[2] <= 1'b0;
         if (open1_in) open_f_q[1] <= 1'b1;
         if (open2_in) open_f_q[2] <= 1'b1;
         if (meas_valid_in) begin
            if (is_rem) begin
               rval_q[rsel] <= corr;
            end else begin
               lval_q <= meas_raw_in[9:2];
            end
            hi_c_q[ch] <= m_hi;
            lo_c_q[ch] <= m_lo;
            th_c_q[ch] <= m_th;
            if (m_hi | m_lo) begin
               if (cnt_q[ch] < need) cnt_q[ch] <= cnt_q[ch] + 3'd1; // [RQ11]
            end else begin
               cnt_q[ch] <= 3'd0;                         // [RQ24]
            end
            if (m_trip & m_hi) hi_f_q[ch] <= 1'b1;
            if (m_trip & m_lo) lo_f_q[ch] <= 1'b1;
         end
      end
   end

   // alarm latch and overtemp comparator output
   wire loc_flags = (hi_f_q[0] | lo_f_q[0]) & ~filt_q[`TMON_FLT_MASK_LOC]; // [RQ15]
   wire any_flag  = loc_flags | (|hi_f_q[2:1]) | (|lo_f_q[2:1]) | (|open_f_q[2:1]);
   always @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         alert_n_q    <= 1'b1;
         overtemp_n_q <= 1'b1;
      end else begin
         alert_n_q    <= ~any_flag;                       // [RQ22]
         overtemp_n_q <= ~(|th_c_q);
      end
   end

   reg sda_lvl_q;                                         // drive level register
   always @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) sda_lvl_q <= 1'b0;
      else sda_lvl_q <= 1'b0;                             // open drain only pulls low
   end

   assign sda_out        = sda_lvl_q;
   assign sda_oe_out     = oe_q;
   assign one_shot_out   = one_shot_q;
   assign alert_n_out    = alert_n_q;
   assign overtemp_n_out = overtemp_n_q;
endmodule // tmon_regs

// *** tmon_regs_sva.sv ***
// port-level assertions for the monitor register bank
`timescale 1ns/1ps
module tmon_regs_sva (
   input wire logic core_clk_in,    // core clock
   input wire logic rst_n_in,       // async reset, active low
   input wire logic scl_in,         // bus clock pin
   input wire logic sda_out,        // data drive level
   input wire logic sda_oe_out,     // data pull-down enable
   input wire logic meas_valid_in,  // measurement strobe
   input wire logic one_shot_out,   // conversion request
   input wire logic alert_n_out,    // alarm, active low
   input wire logic overtemp_n_out  // overtemp, active low
);
   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (!rst_n_in);
   // quiet stretch after a conversion request
   sequence s_shot_gap;
      !one_shot_out [*8];
   endsequence
   // pull-down held well into the low phase
   sequence s_drive_hold;
      sda_oe_out [*3];
   endsequence
   shot_gap_a: assert property (one_shot_out |=> s_shot_gap)
      else $error("conversion request repeated");
   shot_low_a: assert property (one_shot_out |-> !scl_in)
      else $error("conversion request outside low phase");
   ack_edge_a: assert property ($changed(sda_oe_out) |-> !scl_in)
      else $error("data drive changed while clock high");
   ack_hold_a: assert property ($rose(sda_oe_out) |=> s_drive_hold)
      else $error("data drive dropped early");
   drive_low_a: assert property (!sda_out)
      else $error("data line driven high");
   alert_cause_a: assert property ($fell(alert_n_out) |-> $past(meas_valid_in, 2))
      else $error("alarm without measurement");
   overtemp_out_n_cause_a: assert property ($changed(overtemp_n_out) |-> $past(meas_valid_in, 2))
      else $error("overtemp moved without measurement");
   reset_idle_a: assert property ($rose(rst_n_in) |-> alert_n_out && overtemp_n_out && !sda_oe_out)
      else $error("outputs busy after reset");
endmodule // tmon_regs_sva

bind tmon_regs tmon_regs_sva i_tmon_regs_sva (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .scl_in(scl_in),
   .sda_out(sda_out), .sda_oe_out(sda_oe_out), .meas_valid_in(meas_valid_in), .one_shot_out(one_shot_out),
   .alert_n_out(alert_n_out), .overtemp_n_out(overtemp_n_out));

// *** tmon_host.sv ***
// serial bus master model for the monitor
`timescale 1ns/1ps
`include "tmon_defines.vh"
module tmon_host (
   output logic     scl_out,   // bus clock, high between frames
   output logic     sda_m_out, // master data drive, 1 = released
   input wire logic sda_in     // resolved line level
);
   localparam real QT = 31.25; // quarter of a 125 ns bit
   initial begin
      scl_out = 1'b1;
      sda_m_out = 1'b1;
   end
   // start or repeated start: data falls, clock high
   task automatic start();
      sda_m_out = 1'b1;
      #QT scl_out = 1'b1;
      #QT sda_m_out = 1'b0;
      #QT scl_out = 1'b0;
      #QT;
   endtask
   // one bit: data set in low phase, sampled mid-high
   task automatic bit_io(input logic b, output logic r);
      sda_m_out = b;
      #QT scl_out = 1'b1;
      #QT r = sda_in;
      #QT scl_out = 1'b0;
      #QT;
   endtask
   // eight bits msb first, then the ninth slot
   task automatic byte_io(input logic [7:0] d, output logic [7:0] q, output logic ack);
      for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
      bit_io(1'b1, ack);
      ack = ~ack;
   endtask
   // stop: data rises while clock high
   task automatic stop();
      sda_m_out = 1'b0;
      #QT scl_out = 1'b1;
      #QT sda_m_out = 1'b1;
      #(2 * QT);
   endtask
   task automatic wr(input logic [7:0] p, input logic [7:0] d, output logic ok);
      logic [7:0] q;
      logic       a1, a2, a3;
      start();
      byte_io({`TMON_SLV_ADDR, 1'b0}, q, a1);
      byte_io(p, q, a2);
      byte_io(d, q, a3);
      stop();
      ok = a1 & a2 & a3;
   endtask
   // pointer write, repeated start, one byte closed by nack
   task automatic rd(input logic [7:0] p, output logic [7:0] d, output logic ok);
      logic [7:0] q;
      logic       a1, a2, a3, n;
      start();
      byte_io({`TMON_SLV_ADDR, 1'b0}, q, a1);
      byte_io(p, q, a2);
      start();
      byte_io({`TMON_SLV_ADDR, 1'b1}, q, a3);
      byte_io(8'hff, d, n);
      stop();
      ok = a1 & a2 & a3;
   endtask
endmodule // tmon_host

// *** testbench.sv ***
// self-checking bench for the monitor register bank
`timescale 1ns/1ps
module testbench;
   logic       clk = 1'b0;     // core clock
   logic       rst_n = 1'b0;   // reset, active low
   logic       mv = 1'b0;      // measurement strobe
   logic [1:0] mc = 2'd0;      // measurement channel
   logic [9:0] mr = 10'd0;     // raw reading
   logic       bank = 1'b0;    // model of config bit 3
   logic [2:0] th = 3'd0;      // overtemp per channel
   logic       ok;             // all bytes acknowledged
   logic [7:0] q;              // read data
   logic [7:0] mdl [512];      // expected image, bank in bit 8
   logic [7:0] ra [18] = '{8'h00, 8'h01, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h0f,
                           8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h19, 8'h22, 8'h34, 8'h35};
   logic [7:0] fc [4] = '{8'h00, 8'h02, 8'h06, 8'h0e}; // one to four faults
   int         err_total = 0, n_compared = 0, cyc = 0, n_shot = 0, s0;
   wire        scl, sdm, oe, osh, al_n, ot_n;
   wire        sda = sdm & ~oe;  // pull-up: released line reads high
   always #5 clk = ~clk;
   tmon_regs #(.TIMEOUT_CYC(50)) i_tmon_regs (.core_clk_in(clk), .rst_n_in(rst_n), .scl_in(scl), .sda_in(sda),
      .sda_out(), .sda_oe_out(oe), .meas_valid_in(mv), .meas_chan_in(mc), .meas_raw_in(mr), .meas_busy_in(1'b0),
      .open1_in(1'b0), .open2_in(1'b0), .one_shot_out(osh), .alert_n_out(al_n), .overtemp_n_out(ot_n));
   tmon_host i_tmon_host (.scl_out(scl), .sda_m_out(sdm), .sda_in(sda));
   // request counter and hang guard
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (osh === 1'b1) n_shot <= n_shot + 1;
      if (cyc == 80000) begin
         err_total++;
         print_verdict();
      end
   end
   task automatic print_verdict();
      $display("compared %0d, mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cmpb(input logic got, input logic exp);
      cmp({7'h00, got}, {7'h00, exp});
   endtask
   // model slot of an address; banked places follow config bit 3
   function automatic logic [8:0] ix(input logic [7:0] a);
      if (a == 8'h34 || a == 8'h35) return {1'b1, a - 8'h23};
      return {bank && (a == 8'h01 || a == 8'h07 || a == 8'h08 || a == 8'h19 || (a >= 8'h10 && a <= 8'h14)), a};
   endfunction
   // write; split addresses land on their read place
   task automatic w(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] rp;
      rp = (a >= 8'h09 && a <= 8'h0e) ? a - 8'h06 : a;
      i_tmon_host.wr(a, d, ok);
      cmpb(ok, 1'b1);
      if (a != 8'h0f) mdl[ix(rp)] = (a == 8'h12 || a == 8'h35) ? d & 8'hc0 : (a == 8'h22) ? d & 8'hef : d;
      if (a == 8'h09) bank = d[3];
   endtask
   task automatic r(input logic [7:0] a);
      i_tmon_host.rd(a, q, ok);
      cmpb(ok, 1'b1);
      cmp(q, mdl[ix(a)]);
   endtask
   // one reading; remote ones get the signed offset, clamped
   task automatic meas(input logic [1:0] c, input logic [9:0] v);
      logic b;
      int   s;
      b = c[1];
      s = int'(v) + int'($signed({mdl[{b, 8'h11}], mdl[{b, 8'h12}][7:6]}));
      s = s < 0 ? 0 : s > 1023 ? 1023 : s;
      if (c == 2'd0) mdl[9'h000] = v[9:2];
      else mdl[{b, 8'h01}] = 8'(s >> 2);
      if (c != 2'd0) mdl[{b, 8'h10}] = {2'(s), 6'h00};
      if (c != 2'd0) th[c] = (s >> 2) > mdl[{b, 8'h19}];
      @(negedge clk);
      mc = c;
      mr = v;
      mv = 1'b1;
      @(negedge clk);
      mv = 1'b0;
      repeat (3) @(negedge clk);
   endtask
   initial begin
      logic [7:0] hi, lo;
      void'($urandom(32'h5ff6bb97));
      foreach (mdl[i]) mdl[i] = 8'h00;
      mdl[9'h004] = 8'h07;
      mdl[9'h005] = 8'h55;
      mdl[9'h007] = 8'h55;
      mdl[9'h107] = 8'h55;
      mdl[9'h019] = 8'h55;
      mdl[9'h119] = 8'h55;
      mdl[9'h022] = 8'h01;
      repeat (8) @(negedge clk);
      rst_n = 1'b1;
      repeat (4) @(negedge clk);
      foreach (ra[i]) r(ra[i]);
      // a foreign address gets no acknowledge
      i_tmon_host.start();
      i_tmon_host.byte_io(8'h96, q, ok);
      i_tmon_host.stop();
      cmpb(ok, 1'b0);
      // fault filter: count restarts on an in-limit reading
      for (int n = 1; n <= 4; n++) begin
         w(8'h22, fc[n - 1] | {3'b000, 1'($urandom), 3'b000, 1'($urandom)});
         r(8'h22);
         repeat (n - 1) meas(2'd0, 10'h180);
         meas(2'd0, 10'h080);
         repeat (n - 1) meas(2'd0, 10'h180);
         cmpb(al_n, 1'b1);
         meas(2'd0, 10'h180);
         cmpb(al_n, 1'b0);
         meas(2'd0, 10'h080);
         i_tmon_host.rd(8'h02, q, ok);
         cmpb(al_n, 1'b1);
      end
      w(8'h22, 8'h20);
      meas(2'd0, 10'h180);
      cmpb(al_n, 1'b1);
      meas(2'd0, 10'h080);
      i_tmon_host.rd(8'h02, q, ok);
      // single conversion only from standby; alarms not watched
      w(8'h09, 8'h40);
      s0 = n_shot;
      w(8'h0f, 8'($urandom));
      cmp(8'(n_shot - s0), 8'h01);
      w(8'h09, 8'h00);
      w(8'h0f, 8'($urandom));
      cmp(8'(n_shot - s0), 8'h01);
      r(8'h0f);
      // split read and write addresses
      for (int i = 0; i < 5; i++) begin
         w(8'h0a + 8'(i), i == 0 ? 8'($urandom_range(0, 10)) : 8'($urandom));
         r(8'h04 + 8'(i));
      end
      // offsets per bank: extremes first, then random
      for (int k = 0; k < 4; k++) begin
         hi = k == 0 ? 8'h80 : k == 1 ? 8'h7f : 8'($urandom);
         lo = k == 1 ? 8'hff : 8'($urandom);
         w(8'h09, {4'h0, k[0], 3'h0});
         w(8'h11, hi);
         w(8'h12, lo);
         w(8'h13, 8'($urandom));
         w(8'h0d, 8'($urandom));
         foreach (ra[i]) if (ra[i] >= 8'h11 && ra[i] != 8'h22) r(ra[i]);
         r(8'h07);
         meas(k[0] ? 2'd2 : 2'd1, 10'($urandom));
         cmpb(ot_n, ~|th);
         r(8'h01);
         r(8'h10);
      end
      print_verdict();
   end
endmodule // testbench
